// ---- include/ird_pkg.sv ----
// constants, register map and access encodings for the data memory and
// special function register decoder; assumes a single core clock domain.
package ird_pkg;

  // data memory geometry
  localparam int         IRD_DATA_DEPTH     = 256;
  localparam int         IRD_BANK_COUNT     = 4;
  localparam int         IRD_BANK_REGS      = 8;
  localparam int         IRD_BANK_BYTES     = IRD_BANK_COUNT * IRD_BANK_REGS;
  localparam int         IRD_BIT_AREA_BYTES = 16;
  localparam logic [7:0] IRD_BIT_AREA_BASE  = 8'(IRD_BANK_BYTES);
  localparam logic [7:0] IRD_BIT_AREA_LAST  = 8'(IRD_BANK_BYTES + IRD_BIT_AREA_BYTES - 1);
  localparam logic [7:0] IRD_UPPER_BASE     = 8'h80;

  // low nibbles of bit addressable special function registers
  localparam logic [3:0] IRD_BIT_NIBBLE_LO  = 4'h0;
  localparam logic [3:0] IRD_BIT_NIBBLE_HI  = 4'h8;

  // special function register offsets
  localparam logic [7:0] IRD_OFS_PORT0_LATCH    = 8'h80;
  localparam logic [7:0] IRD_OFS_STACK_POINTER  = 8'h81;
  localparam logic [7:0] IRD_OFS_DPTR_LOW       = 8'h82;
  localparam logic [7:0] IRD_OFS_DPTR_HIGH      = 8'h83;
  localparam logic [7:0] IRD_OFS_POWER_CONTROL  = 8'h87;
  localparam logic [7:0] IRD_OFS_TIMER_CONTROL  = 8'h88;
  localparam logic [7:0] IRD_OFS_TIMER_MODE     = 8'h89;
  localparam logic [7:0] IRD_OFS_TIMER0_LOW     = 8'h8a;
  localparam logic [7:0] IRD_OFS_TIMER1_LOW     = 8'h8b;
  localparam logic [7:0] IRD_OFS_TIMER0_HIGH    = 8'h8c;
  localparam logic [7:0] IRD_OFS_TIMER1_HIGH    = 8'h8d;
  localparam logic [7:0] IRD_OFS_PORT1_LATCH    = 8'h90;
  localparam logic [7:0] IRD_OFS_PORT0_CFG_A    = 8'h96;
  localparam logic [7:0] IRD_OFS_PORT0_CFG_B    = 8'h97;
  localparam logic [7:0] IRD_OFS_ADC_SEL_CMP    = 8'h98;
  localparam logic [7:0] IRD_OFS_PORT1_CFG_A    = 8'h9e;
  localparam logic [7:0] IRD_OFS_PORT1_CFG_B    = 8'h9f;
  localparam logic [7:0] IRD_OFS_PORT2_LATCH    = 8'ha0;
  localparam logic [7:0] IRD_OFS_PORT2_CFG_A    = 8'ha6;
  localparam logic [7:0] IRD_OFS_PORT2_CFG_B    = 8'ha7;
  localparam logic [7:0] IRD_OFS_INT_ENABLE     = 8'ha8;
  localparam logic [7:0] IRD_OFS_PORT3_LATCH    = 8'hb0;
  localparam logic [7:0] IRD_OFS_DISP_BANK_SEL  = 8'hb2;
  localparam logic [7:0] IRD_OFS_DISP_TIMING    = 8'hb3;
  localparam logic [7:0] IRD_OFS_SCREEN_FONT    = 8'hb4;

  // reset values
  localparam logic [7:0] IRD_RST_PORT_LATCH     = 8'hff;
  localparam logic [7:0] IRD_RST_STACK_POINTER  = 8'h07;
  localparam logic [7:0] IRD_RST_CFG_A          = 8'hff;
  localparam logic [7:0] IRD_RST_ZERO           = 8'h00;

  localparam int IRD_SFR_COUNT         = 25;
  localparam int IRD_IDX_STACK_POINTER = 1;

  localparam logic [7:0] IRD_SFR_ADDR [IRD_SFR_COUNT] = '{
    IRD_OFS_PORT0_LATCH, IRD_OFS_STACK_POINTER, IRD_OFS_DPTR_LOW, IRD_OFS_DPTR_HIGH,
    IRD_OFS_POWER_CONTROL, IRD_OFS_TIMER_CONTROL, IRD_OFS_TIMER_MODE, IRD_OFS_TIMER0_LOW,
    IRD_OFS_TIMER1_LOW, IRD_OFS_TIMER0_HIGH, IRD_OFS_TIMER1_HIGH, IRD_OFS_PORT1_LATCH,
    IRD_OFS_PORT0_CFG_A, IRD_OFS_PORT0_CFG_B, IRD_OFS_ADC_SEL_CMP, IRD_OFS_PORT1_CFG_A,
    IRD_OFS_PORT1_CFG_B, IRD_OFS_PORT2_LATCH, IRD_OFS_PORT2_CFG_A, IRD_OFS_PORT2_CFG_B,
    IRD_OFS_INT_ENABLE, IRD_OFS_PORT3_LATCH, IRD_OFS_DISP_BANK_SEL, IRD_OFS_DISP_TIMING,
    IRD_OFS_SCREEN_FONT};

  localparam logic [7:0] IRD_SFR_RESET [IRD_SFR_COUNT] = '{
    IRD_RST_PORT_LATCH, IRD_RST_STACK_POINTER, IRD_RST_ZERO, IRD_RST_ZERO,
    IRD_RST_ZERO, IRD_RST_ZERO, IRD_RST_ZERO, IRD_RST_ZERO,
    IRD_RST_ZERO, IRD_RST_ZERO, IRD_RST_ZERO, IRD_RST_PORT_LATCH,
    IRD_RST_CFG_A, IRD_RST_ZERO, IRD_RST_ZERO, IRD_RST_CFG_A,
    IRD_RST_ZERO, IRD_RST_PORT_LATCH, IRD_RST_CFG_A, IRD_RST_ZERO,
    IRD_RST_ZERO, IRD_RST_PORT_LATCH, IRD_RST_ZERO, IRD_RST_ZERO,
    IRD_RST_ZERO};

  // access kinds issued by the core
  typedef enum logic [2:0] {
    IRD_KIND_DIRECT   = 3'b000,
    IRD_KIND_INDIRECT = 3'b001,
    IRD_KIND_BIT      = 3'b010,
    IRD_KIND_REG      = 3'b011,
    IRD_KIND_PUSH     = 3'b100,
    IRD_KIND_POP      = 3'b101
  } ird_kind_e;

  // region reached by an access
  typedef enum logic [2:0] {
    IRD_REG_BANKS   = 3'b000,
    IRD_REG_BITRAM  = 3'b001,
    IRD_REG_SCRATCH = 3'b010,
    IRD_REG_UPPER   = 3'b011,
    IRD_REG_SFR     = 3'b100,
    IRD_REG_NONE    = 3'b101
  } ird_region_e;

endpackage

// ---- include/ird_sfr_if.sv ----
// carrier between the decoder and the special function register bank;
// assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface ird_sfr_if;
  import ird_pkg::*;

  logic [7:0] addr;
  logic       wr_en;
  logic [7:0] wr_data;
  logic       sp_load;
  logic [7:0] sp_value;
  logic       hit;
  logic       bit_capable;
  logic [7:0] rd_data;
  logic [7:0] value [IRD_SFR_COUNT];

  modport decode (output addr, wr_en, wr_data, sp_load, sp_value,
                  input  hit, bit_capable, rd_data, value);
  modport bank   (input  addr, wr_en, wr_data, sp_load, sp_value,
                  output hit, bit_capable, rd_data, value);
endinterface

// ---- test/internal_ram_and_sfr_decode_test.sv ----
// self-checking bench for the data memory and register decoder
// assumes the core stand-in in ird_core_model and the bound checker
`timescale 1ns/1ps
module internal_ram_and_sfr_decode_test;
  import ird_pkg::*;
  logic ref_clk;
  logic rst_b;
  logic acc_valid, acc_write, acc_wbit, rsp_valid, rsp_bit, rsp_unmapped, rsp_cap;
  logic [7:0] acc_addr, acc_wdata, rsp_data;
  logic [1:0] reg_bank;
  ird_kind_e acc_kind;
  ird_region_e rsp_region;
  logic [7:0] sfr_value [IRD_SFR_COUNT];
  logic [7:0] rst_tab [IRD_SFR_COUNT] = '{8'hff, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
  int error_cnt;
  int num_checks;
  int i;
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  ird_core_model u_core (.ref_clk(ref_clk), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_bit(rsp_bit),
    .rsp_unmapped(rsp_unmapped), .rsp_bit_capable(rsp_cap), .acc_kind(acc_kind), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_wbit(acc_wbit), .reg_bank(reg_bank));
  ird_data_mem_decode u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .acc_valid(acc_valid), .acc_kind(acc_kind),
    .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_wbit(acc_wbit), .reg_bank(reg_bank),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_bit(rsp_bit), .rsp_unmapped(rsp_unmapped),
    .rsp_bit_capable(rsp_cap), .rsp_region(rsp_region), .sfr_value(sfr_value));
  // byte and flag comparisons
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    chk8(what, {7'h00, exp}, {7'h00, got});
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // byte accesses; every answer must arrive on the next edge
  task automatic wr(input ird_kind_e kind, input logic [7:0] addr, input logic [7:0] data);
    u_core.acc(kind, 1'b1, addr, data, 1'b0, 2'b00);
    chk1("answer", 1'b1, u_core.r_valid);
  endtask
  task automatic rd(input ird_kind_e kind, input logic [7:0] addr);
    u_core.acc(kind, 1'b0, addr, 8'h00, 1'b0, 2'b00);
    chk1("answer", 1'b1, u_core.r_valid);
  endtask
  // watchdog: a hang ends the run as a failure
  initial begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    final_report();
  end
  initial begin
    error_cnt = 0;
    num_checks = 0;
    rst_b = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    for (i = 0; i < IRD_SFR_COUNT; i++) chk8("reset value", rst_tab[i], sfr_value[i]);
    // every register: old byte on write, new byte on read, bit capability by low nibble
    for (i = 0; i < IRD_SFR_COUNT; i++) begin
      wr(IRD_KIND_DIRECT, IRD_SFR_ADDR[i], 8'(i) ^ 8'h5a);
      chk8("old register", rst_tab[i], u_core.r_data);
    end
    for (i = 0; i < IRD_SFR_COUNT; i++) begin
      rd(IRD_KIND_DIRECT, IRD_SFR_ADDR[i]);
      chk8("register read", 8'(i) ^ 8'h5a, u_core.r_data);
      chk1("bit capable", IRD_SFR_ADDR[i][2:0] == 3'b000, u_core.r_cap);
    end
    wr(IRD_KIND_DIRECT, 8'h84, 8'h3c);
    rd(IRD_KIND_DIRECT, 8'h84);
    chk1("unmapped", 1'b1, u_core.r_unmapped);
    chk8("unmapped data", 8'h00, u_core.r_data);
    // indirect write then read at both ends and across the halfway mark
    for (i = 0; i < 4; i++) begin
      wr(IRD_KIND_INDIRECT, 8'(i * 85), ~8'(i * 85));
      rd(IRD_KIND_INDIRECT, 8'(i * 85));
      chk8("indirect byte", ~8'(i * 85), u_core.r_data);
    end
    chk8("pointer untouched", 8'h5b, sfr_value[IRD_IDX_STACK_POINTER]);
    wr(IRD_KIND_INDIRECT, 8'h81, 8'ha5);
    chk8("upper byte", 8'h5b, sfr_value[IRD_IDX_STACK_POINTER]);
    rd(IRD_KIND_INDIRECT, 8'h81);
    chk8("upper read", 8'ha5, u_core.r_data);
    wr(IRD_KIND_DIRECT, 8'h7f, 8'hc3);
    rd(IRD_KIND_INDIRECT, 8'h7f);
    chk8("direct low", 8'hc3, u_core.r_data);
    // register n=3 of each bank lands at bank*8+3
    for (i = 0; i < 4; i++) begin
      u_core.acc(IRD_KIND_REG, 1'b1, 8'h03, 8'h30 + 8'(i), 1'b0, 2'(i));
      chk1("bank answer", 1'b1, u_core.r_valid);
    end
    for (i = 0; i < 4; i++) begin
      rd(IRD_KIND_DIRECT, 8'(i * 8 + 3));
      chk8("bank byte", 8'h30 + 8'(i), u_core.r_data);
    end
    // stack: pre-increment push and post-decrement pop, both through data memory
    wr(IRD_KIND_DIRECT, IRD_OFS_STACK_POINTER, 8'h30);
    u_core.acc(IRD_KIND_PUSH, 1'b1, 8'h00, 8'h55, 1'b0, 2'b00);
    chk8("push pointer", 8'h31, sfr_value[IRD_IDX_STACK_POINTER]);
    u_core.acc(IRD_KIND_POP, 1'b0, 8'h00, 8'h00, 1'b0, 2'b00);
    chk8("pop byte", 8'h55, u_core.r_data);
    chk8("pop pointer", 8'h30, sfr_value[IRD_IDX_STACK_POINTER]);
    rd(IRD_KIND_INDIRECT, 8'h31);
    chk8("pushed byte", 8'h55, u_core.r_data);
    wr(IRD_KIND_DIRECT, 8'h25, 8'h00);
    u_core.acc(IRD_KIND_BIT, 1'b1, 8'h2c, 8'h00, 1'b1, 2'b00);
    u_core.acc(IRD_KIND_BIT, 1'b0, 8'h2c, 8'h00, 1'b0, 2'b00);
    chk1("bit test", 1'b1, u_core.r_bit);
    rd(IRD_KIND_DIRECT, 8'h25);
    chk8("bit area byte", 8'h10, u_core.r_data);
    u_core.acc(IRD_KIND_BIT, 1'b1, 8'h90, 8'h00, 1'b0, 2'b00);
    chk8("register bit clear", (8'h5a ^ 8'd11) & 8'hfe, sfr_value[11]);
    u_core.idle();
    rst_b = 1'b0;
    @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    chk8("second reset", 8'h07, sfr_value[IRD_IDX_STACK_POINTER]);
    chk8("second reset port", 8'hff, sfr_value[0]);
    chk1("reset answer", 1'b0, rsp_valid);
    final_report();
  end
endmodule

// ---- test/ird_core_model.sv ----
// processor core stand-in: issues one access per call, samples the answer
// assumes calls start just after a rising edge of ref_clk
`timescale 1ns/1ps
module ird_core_model
  import ird_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rsp_valid,
  input wire logic [7:0]  rsp_data,
  input wire logic        rsp_bit,
  input wire logic        rsp_unmapped,
  input wire logic        rsp_bit_capable,
  output ird_pkg::ird_kind_e acc_kind,
  output logic            acc_valid,
  output logic            acc_write,
  output logic [7:0]      acc_addr,
  output logic [7:0]      acc_wdata,
  output logic            acc_wbit,
  output logic [1:0]      reg_bank
);
  logic       r_valid;
  logic [7:0] r_data;
  logic       r_bit;
  logic       r_unmapped;
  logic       r_cap;
  // quiet bus at time zero so nothing is taken during reset
  initial begin
    acc_valid = 1'b0;
    acc_kind = IRD_KIND_DIRECT;
    acc_write = 1'b0;
    acc_addr = 8'h00;
    acc_wdata = 8'h00;
    acc_wbit = 1'b0;
    reg_bank = 2'b00;
  end
  // strobe stays high on exit so the next call runs back to back
  task automatic acc(input ird_kind_e kind, input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                     input logic wbit, input logic [1:0] bank);
    acc_valid = 1'b1;
    acc_kind = kind;
    acc_write = wr;
    acc_addr = addr;
    acc_wdata = wdata;
    acc_wbit = wbit;
    reg_bank = bank;
    @(posedge ref_clk);
    #1;
    r_valid = rsp_valid;
    r_data = rsp_data;
    r_bit = rsp_bit;
    r_unmapped = rsp_unmapped;
    r_cap = rsp_bit_capable;
  endtask
  // release the strobe for one cycle, scrambling the idle address
  task automatic idle();
    acc_valid = 1'b0;
    acc_addr = ~acc_addr;
    @(posedge ref_clk);
    #1;
  endtask
endmodule

// ---- test/ird_decode_props.sv ----
// port checks for the data memory and register decoder
// assumes one clock ref_clk and a synchronous active low rst_b
`timescale 1ns/1ps
module ird_decode_props
  import ird_pkg::*;
(
  input wire logic               ref_clk,
  input wire logic               rst_b,
  input wire logic               acc_valid,
  input wire ird_pkg::ird_kind_e acc_kind,
  input wire logic               acc_write,
  input wire logic [7:0]         acc_addr,
  input wire logic [7:0]         acc_wdata,
  input wire logic               rsp_valid,
  input wire logic [7:0]         rsp_data,
  input wire logic               rsp_unmapped,
  input wire logic               rsp_bit_capable,
  input wire ird_pkg::ird_region_e rsp_region,
  input wire logic [7:0]         sfr_value [ird_pkg::IRD_SFR_COUNT]
);
  logic [7:0] addr_q;
  // previous address, sliced where $past cannot be
  always_ff @(posedge ref_clk) begin
    addr_q <= acc_addr;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence dir_s; acc_valid && acc_kind == IRD_KIND_DIRECT; endsequence
  sequence ind_wr_s; acc_valid && acc_write && acc_kind == IRD_KIND_INDIRECT; endsequence
  sequence ind_rd_s; acc_valid && !acc_write && acc_kind == IRD_KIND_INDIRECT && acc_addr == $past(acc_addr); endsequence
  resp_pulse_a: assert property (acc_valid |=> rsp_valid) else $error("no response after request");
  resp_quiet_a: assert property (!acc_valid |=> !rsp_valid) else $error("response without request");
  mem_persist_a: assert property (ind_wr_s ##1 ind_rd_s |=> rsp_data == $past(acc_wdata, 2))
    else $error("indirect byte not kept");
  low_direct_a: assert property (dir_s ##0 !acc_addr[7] |=> !rsp_unmapped && rsp_region inside
    {IRD_REG_BANKS, IRD_REG_BITRAM, IRD_REG_SCRATCH}) else $error("direct low half not memory");
  upper_direct_a: assert property (dir_s ##0 acc_addr[7] |=> rsp_region == IRD_REG_SFR)
    else $error("direct upper half not a register");
  sp_write_a: assert property (dir_s ##0 acc_write && acc_addr == IRD_OFS_STACK_POINTER
    |=> sfr_value[IRD_IDX_STACK_POINTER] == $past(acc_wdata)) else $error("stack pointer write lost");
  upper_indirect_a: assert property (acc_valid && acc_kind == IRD_KIND_INDIRECT && acc_addr[7]
    |=> rsp_region == IRD_REG_UPPER && !rsp_unmapped) else $error("indirect upper not memory");
  bank_region_a: assert property (dir_s ##0 acc_addr < 8'h20 |=> rsp_region == IRD_REG_BANKS)
    else $error("bank area misdecoded");
  bit_ram_a: assert property (dir_s ##0 acc_addr inside {[8'h20:8'h2f]}
    |=> rsp_region == IRD_REG_BITRAM && rsp_bit_capable) else $error("bit area misdecoded");
  sfr_bit_a: assert property (dir_s ##0 acc_addr[7] |=> rsp_unmapped ||
    rsp_bit_capable == (addr_q[2:0] == 3'b000)) else $error("register bit capability wrong");
  reset_load_a: assert property ($rose(rst_b) |-> sfr_value[0] == 8'hff && !rsp_valid
    && sfr_value[IRD_IDX_STACK_POINTER] == 8'h07) else $error("reset values not loaded");
  // a push moves the pointer up by one; the byte that the push stores is not checked here
  push_step_a: assert property (acc_valid && acc_kind == IRD_KIND_PUSH |=>
    sfr_value[IRD_IDX_STACK_POINTER] == $past(sfr_value[IRD_IDX_STACK_POINTER]) + 8'h01)
    else $error("push pointer step wrong");
endmodule
bind ird_data_mem_decode ird_decode_props u_props (.ref_clk(ref_clk), .rst_b(rst_b), .acc_valid(acc_valid),
  .acc_kind(acc_kind), .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .rsp_valid(rsp_valid),
  .rsp_data(rsp_data), .rsp_unmapped(rsp_unmapped), .rsp_bit_capable(rsp_bit_capable),
  .rsp_region(rsp_region), .sfr_value(sfr_value));

// ---- verilog/ird_data_mem_decode.sv ----
// internal data memory and special function register decoder of the core.
// assumes the core issues at most one access per ref_clk cycle and that
// the working register bank number comes from the core's status word.
`timescale 1ns/1ps

// Summary of operation
// - 256 byte memory, all reachable indirectly
// - direct low half reaches data memory
// - direct upper half selects registers, indirect memory
// - lowest bytes form four eight-register banks
// - sixteen bytes above banks are bit addressable
// - upper memory half is plain indirect storage
// - registers at x0 or x8 are bit addressable
module ird_data_mem_decode (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_b,
  input  wire logic                 acc_valid,
  input  wire ird_pkg::ird_kind_e   acc_kind,
  input  wire logic                 acc_write,
  input  wire logic [7:0]           acc_addr,
  input  wire logic [7:0]           acc_wdata,
  input  wire logic                 acc_wbit,
  input  wire logic [1:0]           reg_bank,
  output logic                      rsp_valid,
  output logic [7:0]                rsp_data,
  output logic                      rsp_bit,
  output logic                      rsp_unmapped,
  output logic                      rsp_bit_capable,
  output ird_pkg::ird_region_e      rsp_region,
  output logic [7:0]                sfr_value [ird_pkg::IRD_SFR_COUNT]
);
  import ird_pkg::*;

  ird_sfr_if sfr_bus ();

  ird_sfr_bank u_sfr_bank (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .sfr     (sfr_bus)
  );

  // storage and decode state
  logic [7:0]  data_mem [IRD_DATA_DEPTH];
  logic [7:0]  byte_addr;
  logic [2:0]  bit_sel;
  logic        to_sfr;
  logic        is_bit;
  logic        is_write;
  logic        kind_ok;
  logic        take;
  logic        stack_op;
  logic [7:0]  sp_now;
  logic [7:0]  sp_step;
  logic [7:0]  rd_byte;
  logic [7:0]  wr_byte;
  logic        mem_we;
  logic        unmapped;
  logic        bit_ok;
  ird_region_e region;

  // response registers
  logic        next_rsp_valid;
  logic [7:0]  next_rsp_data;
  logic        next_rsp_bit;
  logic        next_rsp_unmapped;
  logic        next_rsp_bit_capable;
  ird_region_e next_rsp_region;

  assign sp_now = sfr_bus.value[IRD_IDX_STACK_POINTER];

  // address decode per access kind
  always_comb begin
    byte_addr = acc_addr;
    bit_sel   = acc_addr[2:0];
    to_sfr    = 1'b0;
    is_bit    = 1'b0;
    is_write  = acc_write;
    kind_ok   = 1'b1;
    stack_op  = 1'b0;
    sp_step   = sp_now;
    case (acc_kind)
      IRD_KIND_DIRECT: begin
        // the top address bit alone splits memory from registers
        to_sfr = acc_addr[7];
      end
      IRD_KIND_INDIRECT: begin
        // pointer access covers the full range, never a register
        to_sfr = 1'b0;
      end
      IRD_KIND_BIT: begin
        is_bit = 1'b1;
        if (acc_addr[7]) begin
          // bit number keeps bits 7..3, so only x0/x8 bytes are reached
          byte_addr = {acc_addr[7:3], 3'b000};
          to_sfr    = 1'b1;
        end else begin
          byte_addr = IRD_BIT_AREA_BASE + {4'h0, acc_addr[6:3]};
        end
      end
      IRD_KIND_REG: begin
        // working register Rn of the selected bank
        byte_addr = {3'b000, reg_bank, acc_addr[2:0]};
      end
      IRD_KIND_PUSH: begin
        // pre-increment, then write through the new pointer
        stack_op  = 1'b1;
        is_write  = 1'b1;
        sp_step   = sp_now + 8'h01;
        byte_addr = sp_step;
      end
      IRD_KIND_POP: begin
        // read through the pointer, then post-decrement
        stack_op  = 1'b1;
        is_write  = 1'b0;
        sp_step   = sp_now - 8'h01;
        byte_addr = sp_now;
      end
      default: begin
        kind_ok  = 1'b0;
        is_write = 1'b0;
      end
    endcase
  end

  assign take = acc_valid && kind_ok;

  // register side of the carrier
  assign sfr_bus.addr     = byte_addr;
  assign sfr_bus.wr_data  = wr_byte;
  assign sfr_bus.sp_load  = take && stack_op;
  assign sfr_bus.sp_value = sp_step;

  // a bit request on a register that is not bit capable is refused
  assign bit_ok = !(is_bit && to_sfr) || sfr_bus.bit_capable;

  // unmapped register addresses write nothing and read zero
  assign unmapped = !kind_ok || (to_sfr && !sfr_bus.hit) || !bit_ok;

  assign sfr_bus.wr_en = take && is_write && to_sfr && !unmapped;

  // byte seen by the access before it changes anything
  always_comb begin
    if (to_sfr) begin
      rd_byte = sfr_bus.rd_data;
    end else begin
      rd_byte = data_mem[byte_addr];
    end
  end

  // bit writes merge into the current byte, as read-modify-write
  always_comb begin
    if (is_bit) begin
      wr_byte          = rd_byte;
      wr_byte[bit_sel] = acc_wbit;
    end else if (stack_op) begin
      wr_byte = acc_wdata;
    end else begin
      wr_byte = acc_wdata;
    end
  end

  assign mem_we = take && is_write && !to_sfr;

  // data memory holds no reset; contents are undefined after power up
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      data_mem[byte_addr] <= wr_byte;
    end
  end

  // classify the region reached, for status and debug
  always_comb begin
    if (!kind_ok) begin
      region = IRD_REG_NONE;
    end else if (to_sfr) begin
      region = IRD_REG_SFR;
    end else if (byte_addr < IRD_BIT_AREA_BASE) begin
      region = IRD_REG_BANKS;
    end else if (byte_addr <= IRD_BIT_AREA_LAST) begin
      region = IRD_REG_BITRAM;
    end else if (byte_addr < IRD_UPPER_BASE) begin
      region = IRD_REG_SCRATCH;
    end else begin
      region = IRD_REG_UPPER;
    end
  end

  // next response; every answer arrives one edge after the request
  always_comb begin
    next_rsp_valid       = acc_valid;
    next_rsp_data        = rsp_data;
    next_rsp_bit         = rsp_bit;
    next_rsp_unmapped    = rsp_unmapped;
    next_rsp_bit_capable = rsp_bit_capable;
    next_rsp_region      = rsp_region;
    if (acc_valid) begin
      next_rsp_data        = unmapped ? 8'h00 : rd_byte;
      next_rsp_bit         = unmapped ? 1'b0 : rd_byte[bit_sel];
      next_rsp_unmapped    = unmapped;
      next_rsp_bit_capable = to_sfr ? sfr_bus.bit_capable : (region == IRD_REG_BITRAM);
      next_rsp_region      = region;
    end
    if (!rst_b) begin
      next_rsp_valid       = 1'b0;
      next_rsp_data        = 8'h00;
      next_rsp_bit         = 1'b0;
      next_rsp_unmapped    = 1'b0;
      next_rsp_bit_capable = 1'b0;
      next_rsp_region      = IRD_REG_NONE;
    end
  end

  always_ff @(posedge ref_clk) begin
    rsp_valid       <= next_rsp_valid;
    rsp_data        <= next_rsp_data;
    rsp_bit         <= next_rsp_bit;
    rsp_unmapped    <= next_rsp_unmapped;
    rsp_bit_capable <= next_rsp_bit_capable;
    rsp_region      <= next_rsp_region;
  end

  // register values straight from the bank flip-flops
  assign sfr_value = sfr_bus.value;

endmodule

// ---- verilog/ird_sfr_bank.sv ----
// special function register bank: one byte per mapped address.
// assumes the decoder presents one address per cycle on the carrier.
`timescale 1ns/1ps
module ird_sfr_bank (
  input wire logic ref_clk,
  input wire logic rst_b,
  ird_sfr_if.bank  sfr
);
  import ird_pkg::*;

  logic [IRD_SFR_COUNT-1:0] match;

  genvar g;
  generate
    for (g = 0; g < IRD_SFR_COUNT; g++) begin : g_reg
      logic [7:0] q;
      logic [7:0] next_q;
      assign match[g] = (sfr.addr == IRD_SFR_ADDR[g]);

      // stack update from push/pop never meets a direct write in one cycle
      always_comb begin
        next_q = q;
        if (sfr.wr_en && match[g]) begin
          next_q = sfr.wr_data;
        end
        if ((g == IRD_IDX_STACK_POINTER) && sfr.sp_load) begin
          next_q = sfr.sp_value;
        end
        if (!rst_b) begin
          next_q = IRD_SFR_RESET[g];
        end
      end

      always_ff @(posedge ref_clk) begin
        q <= next_q;
      end

      assign sfr.value[g] = q;
    end
  endgenerate

  // read mux; unmapped addresses read as zero
  always_comb begin
    sfr.rd_data = 8'h00;
    for (int i = 0; i < IRD_SFR_COUNT; i++) begin
      if (match[i]) begin
        sfr.rd_data = sfr.value[i];
      end
    end
  end

  assign sfr.hit = |match;

  // only x0 and x8 addresses accept bit operations
  assign sfr.bit_capable = (sfr.addr[3:0] == IRD_BIT_NIBBLE_LO) ||
                           (sfr.addr[3:0] == IRD_BIT_NIBBLE_HI);
endmodule
